// *** core/cfr_flash_ctrl.sv ***
// The implementer's own choices: the AHB-Lite register port and the register offsets.
`timescale 1ns/100ps

// Function
// (R01) mode bit sets only on a write of 0 then 1; a 0 clears it
// (R02) commands are decoded only while the mode bit is 1
// (R03) command writes to an odd address are ignored
// (R04) commands use the low data byte; program data uses all 16 bits
// (R05) ready/busy bit reads 0 during an automatic operation, else 1
// (R06) writing 1 to bit 3 in mode resets the flash control circuit
// (R07) software waits for ready before releasing the flash reset
// (R08) bit 5 selects the user area, only when booted in boot mode
// (R09) watchdog in mode, reset pin or soft reset restore reset state
// (R10) flash reset during an operation abandons it
// (R11) code FF enters read array; reads return flash words
// (R12) code 70 makes reads return the status on the low byte
// (R13) code 50 clears the program and erase error flags
// (R14) code 40 then a data write programs that word at that address
// (R15) programming or erasing switches to status mode until FF or reset
// (R16) software issues nothing while busy and checks ready first
// (R17) code 20 then D0 at the block top address erases the block
// (R18) software never programs a word twice
// (R19) software sets up bus cycle and masks interrupts before mode
// (R20) software services the watchdog before program or erase
// (R21) code 20 then 20 erases all blocks, ready reports the end
// (R22) with an error flag set, program and erase commands are refused
// (R23) bad erase second code sets both errors; FF cancels to array
// (R24) after reset the status reads 80
// (R25) undefined first codes are ignored without side effects
module cfr_flash_ctrl (
  // clock and reset
  input  wire logic                 i_clk_sys,
  input  wire logic                 i_arst_n,
  // reset sources and boot strap
  input  wire logic                 i_wdt_irq,
  input  wire logic                 i_sw_reset,
  input  wire logic                 i_boot_pin,
  // ahb-lite slave
  input  wire logic                 i_hsel,
  input  wire logic [31:0]          i_haddr,
  input  wire logic [1:0]           i_htrans,
  input  wire logic                 i_hwrite,
  input  wire logic [2:0]           i_hsize,
  input  wire logic [31:0]          i_hwdata,
  input  wire logic                 i_hready,
  output logic                      o_hreadyout,
  output logic [1:0]                o_hresp,
  output logic [31:0]               o_hrdata,
  // flash cell macro
  input  wire logic [15:0]          i_fl_rdata,
  input  wire logic                 i_fl_done,
  input  wire logic                 i_fl_fail,
  output cfr_pkg::cfr_fl_req_s      o_fl_req,
  output logic                      o_user_area
);

  // ==========================================================
  // state
  cfr_pkg::cfr_state_e state, next_state;
  cfr_pkg::cfr_ctrl_s  ctrl, next_ctrl;
  cfr_pkg::cfr_fl_req_s next_fl_req;
  logic [1:0]  errs, next_errs;           // [1] erase, [0] program
  logic        op_ers, next_op_ers;
  logic [16:0] caddr, next_caddr;
  logic        dp_act, next_dp_act, dp_write, next_dp_write;
  logic [31:0] dp_addr, next_dp_addr;
  logic        boot_s1, next_boot_s1, boot_s2, next_boot_s2;
  logic        boot_mode, next_boot_mode;
  logic [1:0]  cap_cnt, next_cap_cnt;
  logic        next_hreadyout, next_user_area;
  logic [31:0] next_hrdata;
  logic        rdy, soft_rst, cmd_wr, cmd_ok;
  logic [7:0]  code;

  // ==========================================================
  // helpers
  function automatic logic [7:0] sr_val(input logic r,
                                        input logic [1:0] e);
    logic [7:0] v;
    v = 8'h00;
    v[cfr_pkg::SR_RDY] = r;
    v[cfr_pkg::SR_ERS] = e[1];
    v[cfr_pkg::SR_PGM] = e[0];
    return v;
  endfunction

  function automatic logic [31:0] ctrl_word(input cfr_pkg::cfr_ctrl_s c,
                                            input logic r);
    logic [31:0] v;
    v = cfr_pkg::RD_ZERO;
    v[cfr_pkg::CTL_RDY]   = r;
    v[cfr_pkg::CTL_MODE]  = c.mode;
    v[cfr_pkg::CTL_FRST]  = c.frst;
    v[cfr_pkg::CTL_UAREA] = c.uarea;
    return v;
  endfunction

  // ready while no automatic operation runs
  assign rdy      = (state != cfr_pkg::ST_BUSY);   // R05
  // watchdog only counts while reprogramming is selected
  assign soft_rst = i_sw_reset | (i_wdt_irq & ctrl.mode);   // R09
  assign cmd_wr   = dp_act & dp_write & (dp_addr == cfr_pkg::OFS_CDATA);
  assign cmd_ok   = cmd_wr & ctrl.mode & ~caddr[0] & ~ctrl.frst
                    & rdy;   // R02 R03
  assign code     = i_hwdata[7:0];   // R04

  // ==========================================================
  // next-state logic for bus, control and sequencer
  always_comb begin
    next_state     = state;
    next_ctrl      = ctrl;
    next_errs      = errs;
    next_op_ers    = op_ers;
    next_caddr     = caddr;
    next_fl_req    = o_fl_req;
    next_fl_req.pgm       = 1'b0;
    next_fl_req.erase     = 1'b0;
    next_fl_req.erase_all = 1'b0;
    next_fl_req.abort     = 1'b0;
    next_dp_act    = 1'b0;
    next_dp_write  = dp_write;
    next_dp_addr   = dp_addr;
    next_hreadyout = 1'b1;
    next_hrdata    = o_hrdata;
    next_boot_s1   = i_boot_pin;
    next_boot_s2   = boot_s1;
    // strap is caught once, after the synchroniser has filled;
    // the counter then parks so a later pin change is not seen until the next pin reset
    next_cap_cnt   = (cap_cnt <= cfr_pkg::STRAP_WAIT) ? cap_cnt + 2'h1
                                                      : cap_cnt;
    next_boot_mode = (cap_cnt == cfr_pkg::STRAP_WAIT) ? boot_s2 : boot_mode;
    // address phase: one wait state keeps hrdata registered
    if (i_hsel && i_hready && i_htrans[1]) begin
      next_dp_act    = 1'b1;
      next_dp_write  = i_hwrite;
      next_dp_addr   = i_haddr;
      next_hreadyout = 1'b0;
    end
    // data phase writes; any other write breaks the 0-then-1 pair
    if (dp_act && dp_write) begin
      next_ctrl.armed = 1'b0;
      if (dp_addr == cfr_pkg::OFS_CTRL) begin
        if (!i_hwdata[cfr_pkg::CTL_MODE]) begin
          next_ctrl.mode  = 1'b0;   // R01
          next_ctrl.armed = 1'b1;
        end else if (ctrl.armed) begin
          next_ctrl.mode  = 1'b1;   // R01
        end
        // the reset bit only arms from mode; a 0 always releases
        next_ctrl.frst  = i_hwdata[cfr_pkg::CTL_FRST] & ctrl.mode; // R06
        next_ctrl.uarea = i_hwdata[cfr_pkg::CTL_UAREA];
      end else if (dp_addr == cfr_pkg::OFS_CADDR) begin
        next_caddr = i_hwdata[cfr_pkg::CADDR_W-1:0];
      end
    end
    // data phase reads
    if (dp_act && !dp_write) begin
      if (dp_addr == cfr_pkg::OFS_CTRL) begin
        next_hrdata = ctrl_word(ctrl, rdy);   // R05
      end else if (dp_addr == cfr_pkg::OFS_CADDR) begin
        next_hrdata = {15'h0000, caddr};
      end else if (dp_addr == cfr_pkg::OFS_CDATA) begin
        if (state == cfr_pkg::ST_ARRAY) begin
          next_hrdata = {16'h0000, i_fl_rdata};   // R11
        end else begin
          next_hrdata = {24'h00_0000, sr_val(rdy, errs)};   // R12
        end
      end else begin
        next_hrdata = cfr_pkg::RD_ZERO;
      end
    end
    // command decoder
    if (cmd_ok) begin
      case (state)
        cfr_pkg::ST_PGM2: begin
          next_fl_req.pgm   = 1'b1;   // R14
          next_fl_req.wdata = i_hwdata[15:0];   // R04
          next_op_ers       = 1'b0;
          next_state        = cfr_pkg::ST_BUSY;   // R15
        end
        cfr_pkg::ST_ERS2: begin
          if (code == cfr_pkg::CMD_CONF) begin
            next_fl_req.erase = 1'b1;   // R17
            next_op_ers       = 1'b1;
            next_state        = cfr_pkg::ST_BUSY;
          end else if (code == cfr_pkg::CMD_ERASE) begin
            next_fl_req.erase_all = 1'b1;   // R21
            next_op_ers           = 1'b1;
            next_state            = cfr_pkg::ST_BUSY;
          end else if (code == cfr_pkg::CMD_ARRAY) begin
            next_state = cfr_pkg::ST_ARRAY;   // R23
          end else begin
            next_errs  = 2'h3;   // R23
            next_state = cfr_pkg::ST_STATUS;
          end
        end
        default: begin
          if (code == cfr_pkg::CMD_ARRAY) begin
            next_state = cfr_pkg::ST_ARRAY;   // R11
          end else if (code == cfr_pkg::CMD_STATUS) begin
            next_state = cfr_pkg::ST_STATUS;   // R12
          end else if (code == cfr_pkg::CMD_CLEAR) begin
            next_errs = 2'h0;   // R13
          end else if (code == cfr_pkg::CMD_PGM && errs == 2'h0) begin
            next_state = cfr_pkg::ST_PGM2;   // R22
          end else if (code == cfr_pkg::CMD_ERASE && errs == 2'h0) begin
            next_state = cfr_pkg::ST_ERS2;   // R22
          end   // R25
          // anything else leaves mode and flags alone
        end
      endcase
    end
    // completion of the automatic operation, result to status
    if (state == cfr_pkg::ST_BUSY && i_fl_done) begin
      next_state = cfr_pkg::ST_STATUS;   // R15
      if (i_fl_fail && op_ers) begin
        next_errs[1] = 1'b1;
      end else if (i_fl_fail) begin
        next_errs[0] = 1'b1;
      end
    end
    // flash reset bit: abandon work and hold the circuit idle
    if (next_ctrl.frst) begin
      next_fl_req.abort = (state == cfr_pkg::ST_BUSY) & ~ctrl.frst; // R10
      next_state        = cfr_pkg::ST_ARRAY;   // R06
      next_errs         = 2'h0;
    end
    // soft reset sources; a bus phase in flight still completes
    if (soft_rst) begin
      next_fl_req.abort = (state == cfr_pkg::ST_BUSY);   // R10
      next_fl_req.pgm       = 1'b0;
      next_fl_req.erase     = 1'b0;
      next_fl_req.erase_all = 1'b0;
      next_state  = cfr_pkg::ST_ARRAY;   // R09
      next_ctrl   = '0;
      next_errs   = 2'h0;   // R24
      next_op_ers = 1'b0;
      next_caddr  = '0;
    end
    next_fl_req.addr = next_caddr[16:1];
    // user area is fixed when not booted from the boot area
    next_user_area = next_boot_mode ? next_ctrl.uarea : 1'b1;   // R08
  end

  // ==========================================================
  // registers
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state       <= cfr_pkg::ST_ARRAY;
      ctrl        <= '0;
      errs        <= 2'h0;   // R24
      op_ers      <= 1'b0;
      caddr       <= '0;
      dp_act      <= 1'b0;
      dp_write    <= 1'b0;
      dp_addr     <= cfr_pkg::RD_ZERO;
      boot_s1     <= 1'b0;
      boot_s2     <= 1'b0;
      boot_mode   <= 1'b0;
      cap_cnt     <= 2'h0;
      o_hreadyout <= 1'b1;
      o_hresp     <= cfr_pkg::HRESP_OKAY;
      o_hrdata    <= cfr_pkg::RD_ZERO;
      o_fl_req    <= '0;
      o_user_area <= 1'b1;
    end else begin
      state       <= next_state;
      ctrl        <= next_ctrl;
      errs        <= next_errs;
      op_ers      <= next_op_ers;
      caddr       <= next_caddr;
      dp_act      <= next_dp_act;
      dp_write    <= next_dp_write;
      dp_addr     <= next_dp_addr;
      boot_s1     <= next_boot_s1;
      boot_s2     <= next_boot_s2;
      boot_mode   <= next_boot_mode;
      cap_cnt     <= next_cap_cnt;
      o_hreadyout <= next_hreadyout;
      o_hresp     <= cfr_pkg::HRESP_OKAY;
      o_hrdata    <= next_hrdata;
      o_fl_req    <= next_fl_req;
      o_user_area <= next_user_area;
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);

  a_mode_needs_arm: assert property ( // R01
    $rose(ctrl.mode) |-> $past(ctrl.armed) && $past(dp_write))
    else $error("mode bit set without a preceding 0 write");
  a_cmd_off_dead: assert property ( // R02
    cmd_wr && !ctrl.mode && rdy && !soft_rst
    |=> state == $past(state) && !o_fl_req.pgm && !o_fl_req.erase)
    else $error("command decoded with mode bit clear");
  a_odd_ignored: assert property ( // R03
    cmd_wr && caddr[0] && rdy && !soft_rst && !i_fl_done
    |=> $stable(errs) && state == $past(state))
    else $error("odd address command was decoded");
  a_pgm_word: assert property ( // R14
    cmd_ok && state == cfr_pkg::ST_PGM2 && !soft_rst && !next_ctrl.frst
    |=> o_fl_req.pgm && !rdy
        && o_fl_req.wdata == $past(i_hwdata[15:0])
        && o_fl_req.addr == $past(caddr[16:1]))
    else $error("program request not issued with full word");
  a_done_status: assert property ( // R15
    state == cfr_pkg::ST_BUSY && i_fl_done && !soft_rst
    && !next_ctrl.frst |=> state == cfr_pkg::ST_STATUS)
    else $error("completion did not enter status mode");
  a_err_refuse: assert property ( // R22
    cmd_ok && errs != 2'h0 && state == cfr_pkg::ST_STATUS
    && (code == cfr_pkg::CMD_PGM || code == cfr_pkg::CMD_ERASE)
    && !soft_rst && !next_ctrl.frst |=> state == cfr_pkg::ST_STATUS)
    else $error("command accepted with error flag set");
  a_seq_error: assert property ( // R23
    cmd_ok && state == cfr_pkg::ST_ERS2 && code != cfr_pkg::CMD_CONF
    && code != cfr_pkg::CMD_ERASE && code != cfr_pkg::CMD_ARRAY
    && !soft_rst && !next_ctrl.frst |=> errs == 2'h3 ##1 errs == 2'h3)
    else $error("sequence error did not set both flags");
  a_abort_busy: assert property ( // R10
    state == cfr_pkg::ST_BUSY && soft_rst
    |=> o_fl_req.abort && rdy && ctrl == '0)
    else $error("reset during operation did not abort");
  a_boot_area: assert property ( // R08
    !boot_mode && cap_cnt > cfr_pkg::STRAP_WAIT |-> ##1 o_user_area)
    else $error("user area deselected outside boot mode");
  c_pgm_done: cover property (
    o_fl_req.pgm ##[1:1000] (i_fl_done && !i_fl_fail));
  c_erase_all: cover property (o_fl_req.erase_all);
  c_seq_err: cover property ($rose(errs == 2'h3));
  c_status_read: cover property (
    dp_act && !dp_write && dp_addr == cfr_pkg::OFS_CDATA
    && state == cfr_pkg::ST_STATUS);

endmodule // cfr_flash_ctrl

// *** core/cfr_pkg.sv ***
package cfr_pkg;

  // ==========================================================
  // register map, byte offsets on the ahb-lite port
  localparam logic [31:0] OFS_CTRL  = 32'h0000_0000;
  localparam logic [31:0] OFS_CADDR = 32'h0000_0004;
  localparam logic [31:0] OFS_CDATA = 32'h0000_0008;
  localparam logic [31:0] RD_ZERO   = 32'h0000_0000;

  // ==========================================================
  // flash_control bit positions
  localparam int CTL_RDY   = 0;
  localparam int CTL_MODE  = 1;
  localparam int CTL_FRST  = 3;
  localparam int CTL_UAREA = 5;

  // ==========================================================
  // command codes, low data byte only
  localparam logic [7:0] CMD_ARRAY  = 8'hff;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR  = 8'h50;
  localparam logic [7:0] CMD_PGM    = 8'h40;
  localparam logic [7:0] CMD_ERASE  = 8'h20;
  localparam logic [7:0] CMD_CONF   = 8'hd0;

  // ==========================================================
  // status readback layout
  localparam int SR_RDY = 7;
  localparam int SR_ERS = 5;
  localparam int SR_PGM = 4;

  // ==========================================================
  // misc widths and values
  localparam int          CADDR_W    = 17;
  localparam logic [1:0]  STRAP_WAIT = 2'h2;
  localparam logic [1:0]  HRESP_OKAY = 2'h0;

  // sequencer states
  typedef enum logic [2:0] {
    ST_ARRAY  = 3'b000,
    ST_STATUS = 3'b001,
    ST_PGM2   = 3'b010,
    ST_ERS2   = 3'b011,
    ST_BUSY   = 3'b100
  } cfr_state_e;

  // request bundle to the flash cell macro
  typedef struct packed {
    logic        pgm;
    logic        erase;
    logic        erase_all;
    logic        abort;
    logic [15:0] addr;
    logic [15:0] wdata;
  } cfr_fl_req_s;

  // software visible control bits, plus the internal 0-then-1 arm flag
  typedef struct packed {
    logic mode;
    logic frst;
    logic uarea;
    logic armed;
  } cfr_ctrl_s;

endpackage

// *** bench/cfr_flash_model.sv ***
`timescale 1ns/100ps

// ==========================================================
// flash cell macro model: slow jobs, patterned array words
module cfr_flash_model #(
  parameter int DLY = 24
) (
  // clock and reset
  input  wire logic                 i_clk_sys,
  input  wire logic                 i_arst_n,
  // request side and fault switch
  input  wire cfr_pkg::cfr_fl_req_s i_req,
  input  wire logic                 i_fail_en,
  // answer side
  output logic [15:0]               o_rdata,
  output logic                      o_done,
  output logic                      o_fail
);
  int cnt;

  // array word follows the address, so a stale address shows
  assign o_rdata = ~i_req.addr;

  // job timer long enough that the bus can see busy
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt    <= 0;
      o_done <= 1'b0;
      o_fail <= 1'b0;
    end else begin
      o_done <= (cnt == 1) && !i_req.abort;
      o_fail <= (cnt == 1) && !i_req.abort && i_fail_en;
      if (i_req.abort) begin
        cnt <= 0;
      end else if (i_req.pgm | i_req.erase | i_req.erase_all) begin
        cnt <= DLY;
      end else if (cnt != 0) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule // cfr_flash_model

// *** bench/tb_top.sv ***
`timescale 1ns/100ps

`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin fails++; \
  $display("[FAIL] %s exp %h got %h", n, e, s); end end

module tb_top;
  // ==========================================================
  // signals
  typedef struct {logic w; logic [31:0] a; logic [31:0] d;} cfr_row_s;
  localparam logic [31:0] C = cfr_pkg::OFS_CTRL;
  localparam logic [31:0] A = cfr_pkg::OFS_CADDR;
  localparam logic [31:0] D = cfr_pkg::OFS_CDATA;
  logic                 clk, rst_n, wdt, swr, boot, hsel, hwrite, fail_en;
  logic                 hready, uarea, done, flf;
  logic [31:0]          haddr, hwdata, hrdata, q;
  logic [1:0]           htrans, hresp;
  logic [2:0]           hsize;
  logic [15:0]          frd, lastw, lasta;
  cfr_pkg::cfr_fl_req_s req;
  int                   fails, cmp_count, npgm, ners, nall, nabt, i;
  cfr_row_s             rows [20];

  cfr_flash_ctrl cfr_flash_ctrl_i (
    .i_clk_sys(clk), .i_arst_n(rst_n), .i_wdt_irq(wdt),
    .i_sw_reset(swr), .i_boot_pin(boot), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
    .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready),
    .o_hreadyout(hready), .o_hresp(hresp), .o_hrdata(hrdata),
    .i_fl_rdata(frd), .i_fl_done(done), .i_fl_fail(flf),
    .o_fl_req(req), .o_user_area(uarea));
  cfr_flash_model cfr_flash_model_i (
    .i_clk_sys(clk), .i_arst_n(rst_n), .i_req(req),
    .i_fail_en(fail_en), .o_rdata(frd), .o_done(done), .o_fail(flf));

  // ==========================================================
  // clock, watchdog and request counting
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    #(8 * 40000);
    fails++;
    complete_run;
  end
  always @(negedge clk) begin   // mid-cycle, before a task looks
    npgm  += int'(req.pgm);
    ners  += int'(req.erase);
    nall  += int'(req.erase_all);
    nabt  += int'(req.abort);
    if (req.pgm) lastw = req.wdata;
    if (req.pgm) lasta = req.addr;
  end

  // ==========================================================
  // bus tasks; waits are bounded since a hang must not pass
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wait_hready;
    int n;
    n = 0;
    @(posedge clk);
    while (hready !== 1'b1) begin
      n++;
      if (n > 50) begin
        fails++;
        complete_run;
      end
      @(posedge clk);
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'b10;
    hwrite <= w;
    wait_hready;
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_hready;
    q = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [31:0] a);
    bus(1'b0, a, 32'h0000_0000);
  endtask
  // poll the ready bit; software must not act while busy
  task automatic poll_rdy;
    for (int k = 0; k < 60; k++) begin
      rd(C);
      if (q[0] === 1'b1) break;
    end
    `CHK("ready", 1'b1, q[0])
  endtask

  // ==========================================================
  // main sequence
  initial begin
    {rst_n, wdt, swr, hsel, hwrite, fail_en, htrans} = '0;
    {haddr, hwdata, hsize, npgm, ners, nall, nabt} = '0;
    boot = 1'b1;
    hsize = 3'h2;
    rows = '{'{1,C,0}, '{0,C,1}, '{1,C,2}, '{0,C,3}, '{1,A,32'h100},
             '{0,A,32'h100}, '{1,D,32'hff}, '{0,D,32'hff7f},
             '{1,D,32'hab70}, '{0,D,32'h80}, '{1,D,32'h33}, '{0,D,32'h80},
             '{1,A,32'h101}, '{1,D,32'hff}, '{0,D,32'h80}, '{1,A,32'h100},
             '{1,D,32'h50}, '{1,D,32'h12ff}, '{0,D,32'hff7f}, '{0,32'h40,0}};
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    // ordinary commands, one row per bus access
    foreach (rows[r]) begin
      bus(rows[r].w, rows[r].a, rows[r].d);
      if (!rows[r].w) `CHK("row", rows[r].d, q)
      `CHK("hresp", cfr_pkg::HRESP_OKAY, hresp)
    end
    $display("test rows done");
    // program: busy seen, full word, status mode after
    wr(D, 32'h40);
    wr(D, 32'ha5c3);
    rd(C);
    `CHK("busy", 1'b0, q[0])
    poll_rdy;
    `CHK("pgm word", 16'ha5c3, lastw)
    `CHK("pgm addr", 16'h0080, lasta)
    rd(D);
    `CHK("status", 32'h80, q)
    // failed program, then refusal until cleared
    wr(A, 32'h102);
    fail_en <= 1'b1;
    wr(D, 32'h40);
    wr(D, 32'h1234);
    poll_rdy;
    fail_en <= 1'b0;
    rd(D);
    `CHK("pgm err", 32'h90, q)
    wr(D, 32'h40);
    wr(D, 32'h5555);
    `CHK("refused", 2, npgm)
    wr(D, 32'h50);
    rd(D);
    `CHK("cleared", 32'h80, q)
    $display("test program done");
    // bad erase second code, then a cancel to array
    wr(D, 32'h20);
    wr(D, 32'h11);
    rd(D);
    `CHK("seq err", 32'hb0, q)
    wr(D, 32'h50);
    wr(D, 32'h20);
    wr(D, 32'hff);
    rd(D);
    `CHK("cancel", 32'hff7e, q)
    // block erase and erase all
    wr(D, 32'h20);
    wr(D, 32'hd0);
    poll_rdy;
    wr(D, 32'h20);
    wr(D, 32'h20);
    poll_rdy;
    `CHK("erase", 1, ners)
    `CHK("erase all", 1, nall)
    $display("test erase done");
    // flash reset in mid program abandons it
    wr(A, 32'h104);
    wr(D, 32'h40);
    wr(D, 32'h7777);
    wr(C, 32'h0a);
    poll_rdy;
    `CHK("abort", 1, nabt)
    wr(C, 32'h02);
    rd(D);
    `CHK("array", 32'hff7d, q)
    // a write to another register between 0 and 1 leaves the mode bit clear
    wr(C, 0);
    wr(A, 32'h100);
    wr(C, 2);
    rd(C);
    `CHK("no mode", 32'h1, q)
    wr(D, 32'h40);
    wr(D, 32'h1);
    `CHK("no cmd", 3, npgm)
    // user area select in boot mode
    `CHK("boot area", 1'b0, uarea)
    wr(C, 32'h20);
    repeat (2) @(posedge clk);
    `CHK("user area", 1'b1, uarea)
    $display("test mode done");
    // soft reset then watchdog, each in the middle of a program
    for (i = 0; i < 2; i++) begin
      wr(C, 0);
      wr(C, 2);
      wr(A, 32'h106 + 4 * i);
      wr(D, 32'h40);
      wr(D, 32'h3c00 + i);
      @(posedge clk);
      {wdt, swr} <= (i == 0) ? 2'b01 : 2'b10;
      @(posedge clk);
      {wdt, swr} <= 2'b00;
      rd(C);
      `CHK("sync reset", 32'h1, q)
      `CHK("sync abort", i + 2, nabt)
    end
    // pin reset in mid run, error flags set and the strap low
    wr(C, 0);
    wr(C, 2);
    wr(D, 32'h20);
    wr(D, 32'h11);
    @(posedge clk);
    rst_n <= 1'b0;
    boot  <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    wr(C, 0);
    wr(C, 2);
    wr(D, 32'h70);
    rd(D);
    `CHK("pin reset", 32'h80, q)
    `CHK("strap user", 1'b1, uarea)
    $display("test reset done");
    complete_run;
  end
endmodule // tb_top
